// ===== inc/sfp_pkg.sv
// Purpose: shared constants and types of the serial flash pin interface
// Assumes: one 200 MHz system clock; the serial clock is sampled as data
// Notes:   register indices are word indices on the plain register port
package sfp_pkg;

  // ********************************************************************
  // register port
  // ********************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  typedef logic [ADDR_W-1:0] sfp_addr_t;
  typedef logic [DATA_W-1:0] sfp_data_t;

  localparam sfp_addr_t REG_CTRL     = 4'h0;
  localparam sfp_addr_t REG_STATUS   = 4'h1;
  localparam sfp_addr_t REG_TXDATA   = 4'h2;
  localparam sfp_addr_t REG_RXDATA   = 4'h3;
  localparam sfp_addr_t REG_STATE    = 4'h4;
  localparam sfp_addr_t REG_MEM_ADDR = 4'h5;
  localparam sfp_addr_t REG_MEM_DATA = 4'h6;

  // ********************************************************************
  // field positions and reset values
  // ********************************************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DRIVE    = 2;
  localparam int SRP_LO_BIT    = 7;   // status_reg_one[7]
  localparam int SRP_HI_BIT    = 8;   // status_reg_two[0]
  localparam int QE_BIT        = 9;   // status_reg_two[1]
  localparam int BP3_BIT       = 5;   // block_protect_bit3
  localparam int BP4_BIT       = 6;   // block_protect_bit4
  localparam int ST_LINK_LSB   = 0;
  localparam int ST_STANDBY    = 2;
  localparam int ST_RXVALID    = 3;
  localparam int ST_WRREJ      = 4;
  localparam int ST_QREF       = 5;
  localparam int ST_IDLEHI     = 6;
  localparam int ST_LOCKED     = 7;
  localparam int ST_BITCNT_LSB = 8;

  localparam sfp_data_t CTRL_RST = 16'h0000;
  localparam sfp_data_t SREG_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [5:0] SYNC_RST = 6'h3c;  // lanes high, clock low, select low

  // ********************************************************************
  // memory of identity and security bytes
  // ********************************************************************
  localparam int MEM_AW        = 11;
  localparam int SEC_REG_CNT   = 3;
  localparam int SEC_REG_BYTES = 512;
  localparam int UID_BYTES     = 16;
  localparam logic [MEM_AW-1:0] UID_BASE = 11'h600;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_DUAL   = 2'b01,
    MODE_QUAD   = 2'b10
  } sfp_mode_t;

  typedef enum logic [1:0] {
    LK_WAIT  = 2'b00,
    LK_DESEL = 2'b01,
    LK_SEL   = 2'b11,
    LK_PAUSE = 2'b10
  } sfp_link_t;

endpackage : sfp_pkg

// ===== inc/sfp_mem_if.sv
// Purpose: carrier between the pin logic and its byte memory
// Assumes: single clock domain
// Notes:   read data is registered inside the memory
`timescale 1ns/10ps
`default_nettype none
interface sfp_mem_if;
  logic [10:0] addr;
  logic [7:0]  wdata;
  logic        we;
  logic [7:0]  rdata;
  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem  (input addr, input wdata, input we, output rdata);
endinterface : sfp_mem_if
`default_nettype wire

// ===== rtl/sfp_secmem.sv
// Purpose: unique number and three security pages, one byte per word
// Assumes: writer and reader share i_ref_clk
// Notes:   read-first; rdata follows the address one edge later
`timescale 1ns/10ps
`default_nettype none
module sfp_secmem (
  input wire logic i_ref_clk,
  sfp_mem_if.mem   mem
);
  import sfp_pkg::*;

  // ********************************************************************
  // storage
  // ********************************************************************
  logic [7:0] mem_q [2**MEM_AW];
  logic [7:0] rdata_q;

  // write port and registered read port
  always_ff @(posedge i_ref_clk) begin
    if (mem.we) begin
      mem_q[mem.addr] <= mem.wdata;
    end
    rdata_q <= mem_q[mem.addr];
  end

  assign mem.rdata = rdata_q;

endmodule : sfp_secmem
`default_nettype wire

// ===== rtl/sfp_pin_if.sv
// Purpose: pin-level serial interface of a serial NOR flash
// Assumes: serial clock far slower than i_ref_clk; pins are asynchronous
// Notes:   core logic sits behind the register port and i_op_busy
`timescale 1ns/10ps
`default_nettype none
module sfp_pin_if (
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst,
  input  wire logic          i_cs_n,
  input  wire logic          i_sclk,
  input  wire logic [3:0]    i_lane,
  output logic      [3:0]    o_lane,
  output logic      [3:0]    o_lane_oe_n,
  input  wire logic          i_op_busy,
  input  wire sfp_pkg::sfp_addr_t i_addr,
  input  wire sfp_pkg::sfp_data_t i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output sfp_pkg::sfp_data_t o_rdata,
  output logic               o_standby,
  output logic               o_region_locked
);
  import sfp_pkg::*;

  // ********************************************************************
  // declarations
  // ********************************************************************
  logic [5:0]  sy1_q, sy2_q, sy3_q;
  logic        cs_s, sclk_s, cs_fall, sclk_rise, sclk_fall;
  logic [3:0]  lane_s;
  sfp_link_t   st_q, st_d;
  sfp_mode_t   mode;
  logic        qe, hw_prot, sel_start;
  logic [2:0]  bitcnt_q, bitcnt_d;
  logic [3:0]  bit_sum;
  logic [7:0]  rx_q, rx_d, tx_q, tx_d;
  logic [7:0]  rxbyte_q, rxbyte_d;
  logic        rxv_set;
  sfp_data_t   ctrl_q, ctrl_d, sreg_q, sreg_d;
  logic [7:0]  txdata_q, txdata_d;
  logic [10:0] maddr_q, maddr_d;
  logic        rxv_q, rxv_d, wrrej_q, wrrej_d;
  logic        qref_q, qref_d, idlehi_q, idlehi_d;
  sfp_data_t   state_word, rdata_d;
  logic [3:0]  lane_d, oe_n_d;
  logic        standby_d, locked_d;
  sfp_mem_if   u_mem_bus ();

  // ********************************************************************
  // helpers
  // ********************************************************************
  // bits moved per serial clock edge
  function automatic logic [3:0] lane_step(input sfp_mode_t m);
    unique case (m)
      MODE_DUAL: lane_step = 4'h2;
      MODE_QUAD: lane_step = 4'h4;
      default:   lane_step = 4'h1;
    endcase
  endfunction : lane_step

  // lanes the device drives in a mode
  function automatic logic [3:0] lane_mask(input sfp_mode_t m);
    unique case (m)
      MODE_DUAL: lane_mask = 4'h3;
      MODE_QUAD: lane_mask = 4'hf;
      default:   lane_mask = 4'h2;
    endcase
  endfunction : lane_mask

  // ********************************************************************
  // pin synchronisers
  // ********************************************************************
  // two flops per pin; the third stage only serves edge detection
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sy1_q <= SYNC_RST;
      sy2_q <= SYNC_RST;
      sy3_q <= SYNC_RST;
    end else begin
      sy1_q <= {i_lane, i_sclk, i_cs_n};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  assign cs_s      = sy2_q[0];
  assign sclk_s    = sy2_q[1];
  assign lane_s    = sy2_q[5:2];
  assign cs_fall   = sy3_q[0] & ~cs_s;
  assign sclk_rise = ~sy3_q[1] & sclk_s;
  assign sclk_fall = sy3_q[1] & ~sclk_s;

  // ********************************************************************
  // mode and protection decode
  // ********************************************************************
  assign qe = sreg_q[QE_BIT];
  // lane 2 is a protect pin only while quad is off
  assign hw_prot = ~qe & ~lane_s[2] & ~sreg_q[SRP_HI_BIT] & sreg_q[SRP_LO_BIT];

  // a quad request without quad enable falls back to single lane
  always_comb begin
    unique case (ctrl_q[CTRL_MODE_LSB +: 2])
      MODE_DUAL: mode = MODE_DUAL;
      MODE_QUAD: mode = qe ? MODE_QUAD : MODE_SINGLE;
      default:   mode = MODE_SINGLE;
    endcase
  end

  // ********************************************************************
  // link state
  // ********************************************************************
  // wait only leaves once select is seen high, so a low select at
  // power-up cannot start a command
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      LK_WAIT: begin
        if (cs_s) st_d = LK_DESEL;
      end
      LK_DESEL: begin
        if (!cs_s) st_d = LK_SEL;
      end
      LK_SEL: begin
        if (cs_s) st_d = LK_DESEL;
        else if (!qe && !lane_s[3] && !sclk_s) st_d = LK_PAUSE;
      end
      LK_PAUSE: begin
        if (cs_s) st_d = LK_DESEL;
        else if (qe || (lane_s[3] && !sclk_s)) st_d = LK_SEL;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_q <= LK_WAIT;
    end else begin
      st_q <= st_d;
    end
  end

  assign sel_start = (st_q == LK_DESEL) && (st_d == LK_SEL);

  // ********************************************************************
  // shift engine
  // ********************************************************************
  // pause simply withholds the edges, so counters keep their position
  always_comb begin
    bitcnt_d = bitcnt_q;
    rx_d     = rx_q;
    tx_d     = tx_q;
    rxbyte_d = rxbyte_q;
    rxv_set  = 1'b0;
    bit_sum  = {1'b0, bitcnt_q} + lane_step(mode);
    if (st_q == LK_DESEL || st_q == LK_WAIT) begin
      bitcnt_d = 3'd0;
      rx_d     = BYTE_RST;
      if (sel_start) tx_d = txdata_q;
    end else if (st_q == LK_SEL && !cs_s) begin
      if (sclk_rise) begin
        unique case (mode)
          MODE_DUAL: rx_d = {rx_q[5:0], lane_s[1:0]};
          MODE_QUAD: rx_d = {rx_q[3:0], lane_s};
          default:   rx_d = {rx_q[6:0], lane_s[0]};
        endcase
        if (bit_sum[3]) begin
          bitcnt_d = 3'd0;
          rxbyte_d = rx_d;
          rxv_set  = 1'b1;
        end else begin
          bitcnt_d = bit_sum[2:0];
        end
      end
      // a falling edge on a byte boundary fetches the next byte
      if (sclk_fall) begin
        tx_d = (bitcnt_q == 3'd0) ? txdata_q : (tx_q << lane_step(mode));
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      bitcnt_q <= 3'd0;
      rx_q     <= BYTE_RST;
      tx_q     <= BYTE_RST;
      rxbyte_q <= BYTE_RST;
    end else begin
      bitcnt_q <= bitcnt_d;
      rx_q     <= rx_d;
      tx_q     <= tx_d;
      rxbyte_q <= rxbyte_d;
    end
  end

  // ********************************************************************
  // register file
  // ********************************************************************
  assign state_word = {5'd0, bitcnt_q, o_region_locked, idlehi_q, qref_q,
                       wrrej_q, rxv_q, o_standby, st_q};

  // sticky flags: a hardware set in the clearing cycle wins
  always_comb begin
    ctrl_d   = ctrl_q;
    sreg_d   = sreg_q;
    txdata_d = txdata_q;
    maddr_d  = maddr_q;
    rdata_d  = '0;
    rxv_d    = rxv_set | (rxv_q & ~(i_rd && i_addr == REG_RXDATA));
    wrrej_d  = wrrej_q;
    qref_d   = qref_q;
    idlehi_d = idlehi_q;
    if (i_wr && i_addr == REG_STATE) begin
      wrrej_d = wrrej_q & ~i_wdata[ST_WRREJ];
      qref_d  = qref_q & ~i_wdata[ST_QREF];
    end
    if (i_wr && i_addr == REG_STATUS && hw_prot) wrrej_d = 1'b1;
    if (sel_start) begin
      idlehi_d = sclk_s;
      if (ctrl_q[CTRL_MODE_LSB +: 2] == MODE_QUAD && !qe) qref_d = 1'b1;
    end
    if (i_wr) begin
      unique case (i_addr)
        REG_CTRL:     ctrl_d   = i_wdata;
        REG_STATUS:   if (!hw_prot) sreg_d = i_wdata;
        REG_TXDATA:   txdata_d = i_wdata[7:0];
        REG_MEM_ADDR: maddr_d  = i_wdata[10:0];
        default:      ;
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        REG_CTRL:     rdata_d = ctrl_q;
        REG_STATUS:   rdata_d = sreg_q;
        REG_TXDATA:   rdata_d = {8'h00, txdata_q};
        REG_RXDATA:   rdata_d = {8'h00, rxbyte_q};
        REG_STATE:    rdata_d = state_word;
        REG_MEM_ADDR: rdata_d = {5'd0, maddr_q};
        REG_MEM_DATA: rdata_d = {8'h00, u_mem_bus.rdata};
        default:      rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctrl_q   <= CTRL_RST;
      sreg_q   <= SREG_RST;
      txdata_q <= BYTE_RST;
      maddr_q  <= '0;
      o_rdata  <= '0;
      rxv_q    <= 1'b0;
      wrrej_q  <= 1'b0;
      qref_q   <= 1'b0;
      idlehi_q <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      sreg_q   <= sreg_d;
      txdata_q <= txdata_d;
      maddr_q  <= maddr_d;
      o_rdata  <= rdata_d;
      rxv_q    <= rxv_d;
      wrrej_q  <= wrrej_d;
      qref_q   <= qref_d;
      idlehi_q <= idlehi_d;
    end
  end

  // security bytes and unique number share one byte memory
  assign u_mem_bus.addr  = maddr_q;
  assign u_mem_bus.wdata = i_wdata[7:0];
  assign u_mem_bus.we    = i_wr && i_addr == REG_MEM_DATA;

  sfp_secmem u_secmem (
    .i_ref_clk (i_ref_clk),
    .mem       (u_mem_bus.mem)
  );

  // ********************************************************************
  // pin and status outputs
  // ********************************************************************
  // drivers decided from the next state so release is never late
  always_comb begin
    unique case (mode)
      MODE_DUAL: lane_d = {2'b00, tx_d[7:6]};
      MODE_QUAD: lane_d = tx_d[7:4];
      default:   lane_d = {2'b00, tx_d[7], 1'b0};
    endcase
    oe_n_d = ~(lane_mask(mode) & {4{st_d == LK_SEL && ctrl_q[CTRL_DRIVE]}});
    // internal writes keep the device active whether paused or not
    standby_d = (st_d == LK_DESEL || st_d == LK_WAIT) && !i_op_busy;
    locked_d  = hw_prot && (sreg_q[BP3_BIT] || sreg_q[BP4_BIT]);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_lane          <= 4'h0;
      o_lane_oe_n     <= 4'hf;
      o_standby       <= 1'b0;
      o_region_locked <= 1'b0;
    end else begin
      o_lane          <= lane_d;
      o_lane_oe_n     <= oe_n_d;
      o_standby       <= standby_d;
      o_region_locked <= locked_d;
    end
  end

  // ********************************************************************
  // assertions
  // ********************************************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  a_desel_released: assert property (
    (st_q != LK_SEL) |-> (o_lane_oe_n == 4'hf))
    else $error("lanes driven while not selected");

  a_standby_busy: assert property (
    (st_q == LK_DESEL && st_d == LK_DESEL) |=> (o_standby == !$past(i_op_busy)))
    else $error("standby does not follow internal busy");

  a_select_active: assert property (
    (st_q == LK_DESEL && !cs_s) |=> (st_q == LK_SEL))
    else $error("select low did not activate");

  a_power_up_edge: assert property (
    (st_q == LK_WAIT && !cs_s) |=> (st_q == LK_WAIT))
    else $error("selected without first falling edge");

  a_rx_on_rise: assert property (
    (st_q == LK_SEL && !sclk_rise) |=> $stable(rx_q))
    else $error("input shifted without rising edge");

  a_tx_on_fall: assert property (
    (st_q == LK_SEL && st_d == LK_SEL && !sclk_fall && !i_wr)
      |=> $stable(o_lane))
    else $error("output changed without falling edge");

  a_single_lanes: assert property (
    (mode == MODE_SINGLE && !i_wr) |=> (o_lane_oe_n[0] && o_lane_oe_n[3:2] == 2'b11))
    else $error("single mode drives an input lane");

  a_wp_blocks: assert property (
    (i_wr && i_addr == REG_STATUS && hw_prot) |=> ($stable(sreg_q) && wrrej_q))
    else $error("protected status write accepted");

  a_pause_entry: assert property (
    (st_q == LK_SEL && !cs_s && !qe && !lane_s[3] && !sclk_s)
      |=> (st_q == LK_PAUSE) ##1 (o_lane_oe_n == 4'hf))
    else $error("pause not entered with clock low");

  a_pause_exit: assert property (
    (st_q == LK_PAUSE && !cs_s && lane_s[3] && sclk_s) |=> (st_q == LK_PAUSE))
    else $error("pause ended while clock high");

  a_quad_no_pause: assert property (
    qe |=> (st_q != LK_PAUSE))
    else $error("pause active with quad enabled");

  a_pause_keeps_pos: assert property (
    (st_q == LK_PAUSE && st_d == LK_PAUSE) |=> ($stable(bitcnt_q) && $stable(tx_q)))
    else $error("bit position lost during pause");

  a_deselect_abort: assert property (
    (st_q == LK_SEL && cs_s) |=> ##1 (bitcnt_q == 3'd0))
    else $error("bit counter not cleared on deselect");

  c_byte_done:  cover property (rxv_set);
  c_pause_seen: cover property (st_q == LK_PAUSE ##1 st_q == LK_SEL);
  c_quad_byte:  cover property (mode == MODE_QUAD && rxv_set);
  c_wr_reject:  cover property (i_wr && i_addr == REG_STATUS && hw_prot);

endmodule : sfp_pin_if
`default_nettype wire

// ===== dv/sfp_host_model.sv
// Purpose: host controller model driving select, serial clock and lanes
// Assumes: clock mode 0, idle low; serial clock period of 125 ns
// Notes:   released lanes are resolved by the bench, not here
`timescale 1ns/10ps
`default_nettype none
module sfp_host_model (
  input  wire logic       i_ref_clk,
  input  wire logic [3:0] i_lane,
  output logic            o_cs_n,
  output logic            o_sclk,
  output logic      [3:0] o_lane,
  output logic      [3:0] o_lane_oe_n
);
  // ******************
  // link tasks
  // ******************
  // select low at power-up, so the device still owes us a falling edge
  initial begin
    o_cs_n      = 1'b0;
    o_sclk      = 1'b0;
    o_lane      = 4'hc;
    o_lane_oe_n = 4'h2;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : ticks

  // select changes only while the clock idles low
  task automatic sel(input logic cs_n);
    @(posedge i_ref_clk);
    o_cs_n <= cs_n;
    ticks(12);
  endtask : sel

  task automatic pins(input logic [3:0] v, input logic [3:0] oe_n);
    @(posedge i_ref_clk);
    o_lane      <= v;
    o_lane_oe_n <= oe_n;
  endtask : pins

  // data set while the clock is low and held across the rise, msb first
  task automatic bits(input int n, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      o_lane[0] <= tx[i];
      ticks(12);
      rx[i] = i_lane[1];
      o_sclk <= 1'b1;
      ticks(13);
      o_sclk <= 1'b0;
    end
  endtask : bits

  // one serial clock period with all four lanes set while low
  task automatic nib(input logic [3:0] v, output logic [3:0] rx);
    o_lane <= v;
    ticks(12);
    rx = i_lane;
    o_sclk <= 1'b1;
    ticks(13);
    o_sclk <= 1'b0;
  endtask : nib

  // park the serial clock at a level, e.g. high across a pause release
  task automatic clk(input logic v);
    @(posedge i_ref_clk);
    o_sclk <= v;
  endtask : clk
endmodule : sfp_host_model
`default_nettype wire

// ===== dv/serial_flash_pin_interface_tb.sv
// Purpose: self-checking bench of the serial flash pin logic
// Assumes: 200 MHz reference clock, host model on the link side
// Notes:   register reads are checked from a queue of expected values
`timescale 1ns/10ps
`default_nettype none
module serial_flash_pin_interface_tb;
  import sfp_pkg::*;
  logic       i_ref_clk = 1'b0;
  logic       i_rst     = 1'b1;
  logic       i_op_busy = 1'b0;
  logic       i_wr      = 1'b0;
  logic       i_rd      = 1'b0;
  logic       rd_d      = 1'b0;
  logic       tog       = 1'b0;
  sfp_addr_t  i_addr    = '0;
  sfp_data_t  i_wdata   = '0;
  sfp_data_t  o_rdata;
  logic [3:0] o_lane, o_lane_oe_n, h_lane, h_oe_n, lane_w;
  logic       o_standby, o_region_locked, h_cs_n, h_sclk;
  logic [7:0] tx, d, r, r2, j;
  logic [3:0] n;
  sfp_data_t  eq[$], mq[$];
  sfp_data_t  ma[4] = '{16'h0000, 16'h03ff, 16'h05ff, 16'h060f};
  int         seed, miscompares = 0, num_checks = 0;

  // ******************
  // clock, wire and instances
  // ******************
  always #2.5 i_ref_clk = ~i_ref_clk;

  // unpulled lanes nobody drives wander, so stale values never look valid
  always @(posedge i_ref_clk) tog <= ~tog;
  always_comb
    for (int b = 0; b < 4; b++)
      lane_w[b] = !o_lane_oe_n[b] ? o_lane[b] : !h_oe_n[b] ? h_lane[b] : (b > 1) ? 1'b1 : tog;

  sfp_pin_if sfp_pin_if_inst (
    .i_ref_clk       (i_ref_clk),
    .i_rst           (i_rst),
    .i_cs_n          (h_cs_n),
    .i_sclk          (h_sclk),
    .i_lane          (lane_w),
    .o_lane          (o_lane),
    .o_lane_oe_n     (o_lane_oe_n),
    .i_op_busy       (i_op_busy),
    .i_addr          (i_addr),
    .i_wdata         (i_wdata),
    .i_wr            (i_wr),
    .i_rd            (i_rd),
    .o_rdata         (o_rdata),
    .o_standby       (o_standby),
    .o_region_locked (o_region_locked)
  );
  sfp_host_model host (
    .i_ref_clk   (i_ref_clk),
    .i_lane      (lane_w),
    .o_cs_n      (h_cs_n),
    .o_sclk      (h_sclk),
    .o_lane      (h_lane),
    .o_lane_oe_n (h_oe_n)
  );

  // ******************
  // tasks
  // ******************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input sfp_addr_t a, input sfp_data_t v);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    @(posedge i_ref_clk);
  endtask : wr

  task automatic rd(input sfp_addr_t a, input sfp_data_t e, input sfp_data_t m);
    eq.push_back(e);
    mq.push_back(m);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(posedge i_ref_clk);
  endtask : rd

  task automatic test_done;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  // read data stand one cycle after the strobe; compare with the oldest note
  always @(posedge i_ref_clk) begin
    rd_d <= i_rd;
    if (rd_d)
      chk(o_rdata & mq.pop_front(), eq.pop_front());
  end

  // watchdog sized well above the whole sequence
  initial begin
    #400000;
    miscompares++;
    test_done();
  end

  // ******************
  // main sequence
  // ******************
  initial begin
    seed = 32'haa97;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    host.ticks(6);
    rd(REG_STATE, 16'h0000, 16'h0003);
    rd(REG_CTRL, CTRL_RST, 16'hffff);
    rd(REG_STATUS, SREG_RST, 16'hffff);
    rd(4'hf, 16'h0000, 16'hffff);
    $display("test reset done");
    // deselect while an internal write runs, then let it finish
    i_op_busy <= 1'b1;
    host.sel(1'b1);
    chk(o_standby, 16'h0000);
    chk(o_lane_oe_n, 16'h000f);
    rd(REG_STATE, 16'h0001, 16'h0003);
    i_op_busy <= 1'b0;
    host.ticks(4);
    chk(o_standby, 16'h0001);
    $display("test standby done");
    // one full byte each way in single mode
    tx = 8'($random(seed));
    d = 8'($random(seed));
    wr(REG_TXDATA, {8'h00, tx});
    wr(REG_CTRL, 16'h0004);
    host.sel(1'b0);
    chk(o_lane_oe_n, 16'h000d);
    host.bits(8, d, r);
    chk(r, tx);
    host.ticks(6);
    rd(REG_RXDATA, {8'h00, d}, 16'h00ff);
    host.sel(1'b1);
    $display("test single done");
    // pause mid-byte with clock pulses inside it, then resume
    tx = 8'($random(seed));
    d = 8'($random(seed));
    wr(REG_TXDATA, {8'h00, tx});
    host.sel(1'b0);
    host.bits(4, d, r);
    host.pins(4'h4, 4'h2);
    host.ticks(8);
    rd(REG_STATE, 16'h0002, 16'h0003);
    chk(o_lane_oe_n, 16'h000f);
    host.bits(2, 8'hff, j);
    // pause released while the clock is high must wait for it to fall
    host.clk(1'b1);
    host.pins(4'hc, 4'h2);
    host.ticks(8);
    rd(REG_STATE, 16'h0002, 16'h0003);
    host.clk(1'b0);
    host.ticks(4);
    rd(REG_STATE, 16'h0003, 16'h0003);
    host.ticks(8);
    host.bits(4, {d[3:0], 4'h0}, r2);
    chk({r[7:4], r2[7:4]}, tx);
    host.ticks(6);
    rd(REG_RXDATA, {8'h00, d}, 16'h00ff);
    // abort a partial byte by deselecting
    host.bits(3, d, r);
    host.sel(1'b1);
    rd(REG_STATE, 16'h0001, 16'h0703);
    $display("test pause done");
    // hardware protect: status write refused, regions locked
    wr(REG_STATUS, 16'h00e0);
    rd(REG_STATUS, 16'h00e0, 16'hffff);
    host.sel(1'b0);
    chk(o_region_locked, 16'h0000);
    host.pins(4'h8, 4'h2);
    host.ticks(6);
    chk(o_region_locked, 16'h0001);
    wr(REG_STATUS, 16'h0000);
    rd(REG_STATUS, 16'h00e0, 16'hffff);
    rd(REG_STATE, 16'h0010, 16'h0010);
    host.sel(1'b1);
    $display("test protect done");
    // quad mode refused, then granted by quad enable
    wr(REG_CTRL, 16'h0006);
    host.sel(1'b0);
    rd(REG_STATE, 16'h0020, 16'h0020);
    chk(o_lane_oe_n, 16'h000d);
    host.sel(1'b1);
    host.pins(4'hc, 4'h2);
    host.ticks(4);
    wr(REG_STATUS, 16'h02e0);
    host.pins(4'h8, 4'h2);
    host.ticks(6);
    chk(o_region_locked, 16'h0000);
    host.pins(4'h0, 4'hf);
    host.sel(1'b0);
    chk(o_lane_oe_n, 16'h0000);
    rd(REG_STATE, 16'h0003, 16'h0003);
    // quad byte out on all four lanes, then a byte in with drive off
    host.nib(4'h0, n);
    r[7:4] = n;
    host.nib(4'h0, n);
    chk({r[7:4], n}, tx);
    wr(REG_CTRL, 16'h0002);
    host.pins(4'h0, 4'h0);
    host.ticks(2);
    host.nib(d[7:4], n);
    host.nib(d[3:0], n);
    host.ticks(6);
    rd(REG_RXDATA, {8'h00, d}, 16'h00ff);
    host.pins(4'h0, 4'hf);
    host.sel(1'b1);
    chk(o_lane_oe_n, 16'h000f);
    $display("test quad done");
    // dual byte out, two bits per falling edge
    wr(REG_CTRL, 16'h0005);
    host.sel(1'b0);
    chk(o_lane_oe_n, 16'h000c);
    for (int p = 0; p < 4; p++) begin
      host.nib(4'h0, n);
      r = {r[5:0], n[1:0]};
    end
    chk(r, tx);
    host.sel(1'b1);
    $display("test dual done");
    // security pages and unique number, one boundary byte each
    foreach (ma[k]) begin
      d = 8'($random(seed));
      wr(REG_MEM_ADDR, ma[k]);
      wr(REG_MEM_DATA, {8'h00, d});
      wr(REG_MEM_ADDR, ma[k]);
      host.ticks(2);
      rd(REG_MEM_DATA, {8'h00, d}, 16'h00ff);
    end
    host.ticks(4);
    $display("test memory done");
    test_done();
  end
endmodule : serial_flash_pin_interface_tb
`default_nettype wire
